// ==== cssio_pkg.sv ====
// Package: constants and types for the clocked serial shift unit
package cssio_pkg;
   localparam int         ADDR_W       = 3;
   localparam logic [2:0] ADDR_PORT_E  = 3'h0;
   localparam logic [2:0] ADDR_PORT_F  = 3'h1;
   localparam logic [2:0] ADDR_MODE    = 3'h2;
   localparam logic [2:0] ADDR_START   = 3'h3;
   localparam logic [2:0] ADDR_STOP    = 3'h4;
   localparam logic [2:0] ADDR_COUNT   = 3'h5;
   localparam logic [2:0] ADDR_STATUS  = 3'h6;
   localparam int         MODE_SO      = 0;
   localparam int         MODE_SHIFT   = 1;
   localparam int         MODE_SRC     = 3;
   localparam int         JUDGE_BIT    = 3;
   localparam int         ST_JUDGE     = 0;
   localparam int         ST_PIN       = 1;
   localparam int         ST_STARTED   = 2;
   localparam logic [3:0] MODE_RESET   = 4'h0;
   localparam logic [3:0] CNT_RESET    = 4'h0;
   localparam logic [7:0] SHIFT_RESET  = 8'h00;
   localparam int         CLK_NS       = 25;
   localparam int         INSTR_NS     = 33300;
   localparam int         HALF_CYC     = (INSTR_NS + CLK_NS - 1) / CLK_NS;
   localparam int         HALF_W       = 11;
   localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(HALF_CYC - 1);

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [3:0]        wdata;
   } cssio_bus_t;

   typedef enum logic [2:0] {
      GEN_IDLE = 3'b001,
      GEN_HIGH = 3'b010,
      GEN_LOW  = 3'b100
   } cssio_gen_t;
endpackage : cssio_pkg

// ==== cssio_top.sv ====
// Module: clocked serial shift unit with shifter, counter and clock generator
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module cssio_top (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // Register port
   input  wire cssio_pkg::cssio_bus_t bus,
   output logic [3:0]             rdata,
   // Serial pins
   input  wire logic              sck_in,
   output logic                   sck_out,
   output logic                   sck_oe,
   input  wire logic              si_in,
   output logic                   so_out,
   // Judge line to the core
   output logic                   shift_end_judge
);
   import cssio_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0]        shifter;
   logic [3:0]        cnt;
   logic [3:0]        mode;
   logic              started;
   cssio_gen_t        gen;
   logic [HALF_W-1:0] half;
   logic              sck_s1, sck_s2, sck_s3;
   logic              si_s1, si_s2;
   logic [7:0]        next_shifter;
   logic [3:0]        next_cnt;
   logic [3:0]        next_mode;
   logic              next_started;
   cssio_gen_t        next_gen;
   logic [HALF_W-1:0] next_half;
   logic [3:0]        next_rdata;
   logic              next_sck_out;
   logic              next_sck_oe;
   logic              next_so;
   logic              next_judge;
   logic              src, sh_en, autostop, half_end;
   logic              int_rise, int_fall, ext_rise, ext_fall, rise, fall;
   logic              wr_e, wr_f, start, stop;

   ////////////////////////////////////////////////////////////////////////
   // Next values
   always_comb begin
      src      = mode[MODE_SRC];
      sh_en    = mode[MODE_SHIFT];
      autostop = src & sh_en;
      half_end = (half == HALF_LAST);
      wr_e     = bus.wr && bus.addr == ADDR_PORT_E;
      wr_f     = bus.wr && bus.addr == ADDR_PORT_F;
      start    = bus.wr && bus.addr == ADDR_START;
      stop     = bus.wr && bus.addr == ADDR_STOP;
      ext_rise = sck_s2 & ~sck_s3;
      ext_fall = ~sck_s2 & sck_s3;
      int_rise = (gen == GEN_LOW) && half_end;
      int_fall = (gen == GEN_HIGH) && half_end && !(autostop && shift_end_judge);
      rise     = src ? int_rise : ext_rise;
      fall     = src ? int_fall : ext_fall;
      next_shifter = shifter;
      next_cnt     = cnt;
      next_mode    = mode;
      next_started = started;
      next_gen     = gen;
      next_half    = half;
      next_so      = so_out;
      // Generator: high half, then active low half
      unique case (gen)
         GEN_IDLE: next_half = '0;
         GEN_HIGH: begin
            if (autostop && shift_end_judge) begin
               next_gen  = GEN_IDLE;
               next_half = '0;
            end else if (half_end) begin
               next_gen  = GEN_LOW;
               next_half = '0;
            end else begin
               next_half = half + 1'b1;
            end
         end
         GEN_LOW: begin
            if (half_end) begin
               next_gen  = GEN_HIGH;
               next_half = '0;
            end else begin
               next_half = half + 1'b1;
            end
         end
      endcase
      if (!src) begin
         next_gen  = GEN_IDLE;
         next_half = '0;
      end
      // Shift path, gated by enable
      if (sh_en && fall) begin
         next_so = shifter[7];
      end
      if (sh_en && rise) begin
         next_shifter = {shifter[6:0], si_s2};
         next_cnt     = cnt + 1'b1;
      end
      if (wr_e) begin
         next_shifter[3:0] = bus.wdata;
      end
      if (wr_f) begin
         next_shifter[7:4] = bus.wdata;
      end
      if (start) begin
         next_mode    = bus.wdata;
         next_started = 1'b1;
         next_cnt     = CNT_RESET;
         next_half    = '0;
         next_gen     = bus.wdata[MODE_SRC] ? GEN_HIGH : GEN_IDLE;
      end
      if (stop) begin
         next_mode = MODE_RESET;
         next_cnt  = CNT_RESET;
         next_gen  = GEN_IDLE;
         next_half = '0;
      end
      next_judge   = next_cnt[JUDGE_BIT];
      next_sck_out = (next_gen != GEN_LOW);
      next_sck_oe  = next_started & next_mode[MODE_SRC];
      next_rdata   = 4'h0;
      if (bus.rd) begin
         case (bus.addr)
            ADDR_PORT_E: next_rdata = shifter[3:0];
            ADDR_PORT_F: next_rdata = shifter[7:4];
            ADDR_MODE:   next_rdata = mode;
            ADDR_COUNT:  next_rdata = cnt;
            ADDR_STATUS: begin
               next_rdata[ST_JUDGE]   = shift_end_judge;
               next_rdata[ST_PIN]     = sck_s2;
               next_rdata[ST_STARTED] = started;
            end
            default:     next_rdata = 4'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         shifter         <= SHIFT_RESET;
         cnt             <= CNT_RESET;
         mode            <= MODE_RESET;
         started         <= 1'b0;
         gen             <= GEN_IDLE;
         half            <= '0;
         rdata           <= 4'h0;
         sck_out         <= 1'b1;
         sck_oe          <= 1'b0;
         so_out          <= 1'b0;
         shift_end_judge <= 1'b0;
         sck_s1          <= 1'b1;
         sck_s2          <= 1'b1;
         sck_s3          <= 1'b1;
         si_s1           <= 1'b0;
         si_s2           <= 1'b0;
      end else begin
         shifter         <= next_shifter;
         cnt             <= next_cnt;
         mode            <= next_mode;
         started         <= next_started;
         gen             <= next_gen;
         half            <= next_half;
         rdata           <= next_rdata;
         sck_out         <= next_sck_out;
         sck_oe          <= next_sck_oe;
         so_out          <= next_so;
         shift_end_judge <= next_judge;
         sck_s1          <= sck_in;
         sck_s2          <= sck_s1;
         sck_s3          <= sck_s2;
         si_s1           <= si_in;
         si_s2           <= si_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_port_read;
      @(posedge mclk) disable iff (sys_rst)
      bus.rd && bus.addr == ADDR_PORT_F |=> rdata == $past(shifter[7:4]);
   endproperty
   a_port_read: assert property (p_port_read) else $error("port read bad");

   property p_shift_gate;
      @(posedge mclk) disable iff (sys_rst)
      !sh_en && !wr_e && !wr_f |=> shifter == $past(shifter);
   endproperty
   a_shift_gate: assert property (p_shift_gate) else $error("gated shift");

   property p_shift_dir;
      @(posedge mclk) disable iff (sys_rst)
      sh_en && rise && !wr_e && !wr_f |=>
         shifter == {$past(shifter[6:0]), $past(si_s2)};
   endproperty
   a_shift_dir: assert property (p_shift_dir) else $error("shift wrong");

   property p_so_fall;
      @(posedge mclk) disable iff (sys_rst)
      sh_en && fall |=> so_out == $past(shifter[7]);
   endproperty
   a_so_fall: assert property (p_so_fall) else $error("serial out bad");

   property p_judge;
      @(posedge mclk) disable iff (sys_rst)
      shift_end_judge == cnt[JUDGE_BIT];
   endproperty
   a_judge: assert property (p_judge) else $error("judge mismatch");

   property p_clear;
      @(posedge mclk) disable iff (sys_rst)
      start || stop |=> cnt == CNT_RESET && !shift_end_judge;
   endproperty
   a_clear: assert property (p_clear) else $error("count not cleared");

   property p_halt;
      @(posedge mclk) disable iff (sys_rst)
      gen == GEN_HIGH && autostop && shift_end_judge && !start && !stop
         |=> gen == GEN_IDLE ##1 sck_out;
   endproperty
   a_halt: assert property (p_halt) else $error("clock not halted");

   property p_half;
      @(posedge mclk) disable iff (sys_rst)
      $rose(gen == GEN_LOW) |-> $past(half) == HALF_LAST;
   endproperty
   a_half: assert property (p_half) else $error("half period bad");

   property p_run_on;
      @(posedge mclk) disable iff (sys_rst)
      gen == GEN_LOW && half_end && src && !start && !stop |=> gen == GEN_HIGH;
   endproperty
   a_run_on: assert property (p_run_on) else $error("clock stopped");

   property p_restart;
      @(posedge mclk) disable iff (sys_rst)
      start && bus.wdata[MODE_SRC] |=> gen == GEN_HIGH ##1 sck_out;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart high");

   property p_float;
      @(posedge mclk) disable iff (sys_rst)
      !started |-> !sck_oe;
   endproperty
   a_float: assert property (p_float) else $error("pin driven early");

   property p_stop_mode;
      @(posedge mclk) disable iff (sys_rst)
      stop |=> mode == MODE_RESET && !sck_oe;
   endproperty
   a_stop_mode: assert property (p_stop_mode) else $error("mode kept");

   property p_ext_count;
      @(posedge mclk) disable iff (sys_rst)
      !src && sh_en && ext_rise && !start && !stop |=>
         cnt == 4'($past(cnt) + 4'h1);
   endproperty
   a_ext_count: assert property (p_ext_count) else $error("ext count bad");
endmodule : cssio_top

// ==== cssio_peer.sv ====
// Far-side serial device: clocks, sends and captures bytes
`timescale 1ns/1ps
module cssio_peer (
   // Shared clock pin and data lines
   input  wire logic       pin,
   input  wire logic       so,
   output logic            ext_sck,
   output logic            si,
   // Frame control from the bench
   input  wire logic       go,
   input  wire logic [4:0] n_clk,
   input  wire logic [7:0] tx,
   output logic [7:0]      rx,
   output logic            busy
);
   int k;
   initial begin
      ext_sck = 1'b1;
      si      = 1'b0;
      rx      = 8'h00;
      busy    = 1'b0;
      k       = 0;
   end
   // Burst of n clocks, then the pin rests at the pull-up level
   always @(posedge go) begin
      // Pin and data move clear of the device clock edges
      #5;
      busy = 1'b1;
      rx   = 8'h00;
      k    = 0;
      si   = tx[7];
      repeat (n_clk) begin
         #100 ext_sck = 1'b0;
         #100 ext_sck = 1'b1;
      end
      busy = 1'b0;
   end
   // Next bit, MSB first, on each falling pin edge
   always @(negedge pin) si = tx[7 - (k % 8)];
   // Device output is taken well clear of its own update
   always @(posedge pin) begin
      k++;
      #90 rx = {rx[6:0], so};
   end
endmodule : cssio_peer

// ==== cssio_top_tb.sv ====
// Bench: serial shift unit against a behavioural peer and model
`timescale 1ns/1ps
module cssio_top_tb;
   import cssio_pkg::*;
   cssio_bus_t bus;
   logic       mclk, sys_rst, go, pin, sck_out, sck_oe, so_out, judge;
   logic       ext_sck, si, busy;
   logic [3:0] rdata, d, hi;
   logic [4:0] n_clk;
   logic [7:0] tx, rx, m, old, r;
   int         failures, tests_run, seed, cnt, falls, c, f;
   assign pin = sck_oe ? sck_out : ext_sck;
   cssio_top dut (.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
      .rdata(rdata), .sck_in(pin), .sck_out(sck_out), .sck_oe(sck_oe),
      .si_in(si), .so_out(so_out), .shift_end_judge(judge));
   cssio_peer peer (.pin(pin), .so(so_out), .ext_sck(ext_sck), .si(si),
      .go(go), .n_clk(n_clk), .tx(tx), .rx(rx), .busy(busy));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(negedge sck_out) falls++;
   ////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [3:0] v);
      bus <= '{1'b0, 1'b1, a, v};
      @(posedge mclk);
      bus <= '0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [2:0] a);
      bus <= '{1'b1, 1'b0, a, 4'h0};
      @(posedge mclk);
      bus <= '0;
      @(posedge mclk);
      d = rdata;
   endtask : rd
   task automatic rd8;
      rd(ADDR_PORT_F);
      hi = d;
      rd(ADDR_PORT_E);
      r = {hi, d};
   endtask : rd8
   task automatic frame(input logic [4:0] n);
      tx = 8'($random(seed));
      n_clk <= n;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      for (cnt = 0; cnt < 400 && (busy !== 1'b0 || cnt < 2); cnt++)
         @(posedge mclk);
      if (cnt == 400) begin
         failures++;
         summarize();
      end
      repeat (6) @(posedge mclk);
   endtask : frame
   ////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h905a;
      failures = 0;
      tests_run = 0;
      sys_rst = 1'b1;
      bus = '0;
      go = 1'b0;
      n_clk = 5'h0;
      tx = 8'h00;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      chk({7'h0, sck_oe}, 8'h00);
      chk({7'h0, judge}, 8'h00);
      rd(3'h7);
      chk({4'h0, d}, 8'h00);
      m = 8'($random(seed));
      wr(ADDR_PORT_E, m[3:0]);
      wr(ADDR_PORT_F, m[7:4]);
      rd8();
      chk(r, m);
      $display("reset and ports done");
      wr(ADDR_START, 4'h0);
      frame(8);
      rd8();
      chk(r, m);
      rd(ADDR_COUNT);
      chk({4'h0, d}, 8'h00);
      $display("shift disabled done");
      c = 0;
      wr(ADDR_START, 4'h2);
      for (f = 0; f < 3; f++) begin
         old = m;
         frame(8);
         m = tx;
         c = (c + 8) % 16;
         rd8();
         chk(r, m);
         chk(rx, old);
         chk({7'h0, judge}, 8'(c >= 8));
         rd(ADDR_COUNT);
         chk({4'h0, d}, 8'(c));
      end
      wr(ADDR_START, 4'h2);
      rd(ADDR_COUNT);
      chk({4'h0, d}, 8'h00);
      frame(4);
      m = {m[3:0], tx[7:4]};
      rd8();
      chk(r, m);
      rd(ADDR_COUNT);
      chk({4'h0, d}, 8'h04);
      $display("external frames done");
      falls = 0;
      wr(ADDR_START, 4'hA);
      chk({6'h0, sck_oe, sck_out}, 8'h03);
      frame(0);
      for (cnt = 0; cnt < 22000 && judge !== 1'b1; cnt++)
         @(posedge mclk);
      if (cnt == 22000) begin
         failures++;
         summarize();
      end
      repeat (4 * HALF_CYC) @(posedge mclk);
      chk(8'(falls), 8'h08);
      chk({7'h0, sck_out}, 8'h01);
      rd(ADDR_STATUS);
      chk({4'h0, d}, 8'h07);
      old = m;
      m = tx;
      rd8();
      chk(r, m);
      chk(rx, old);
      rd(ADDR_MODE);
      chk({4'h0, d}, 8'h0A);
      $display("internal frame done");
      falls = 0;
      wr(ADDR_START, 4'h8);
      repeat (24000) @(posedge mclk);
      chk(8'(falls), 8'h09);
      rd8();
      chk(r, m);
      wr(ADDR_STOP, 4'h0);
      rd(ADDR_MODE);
      chk({4'h0, d}, 8'h00);
      rd(ADDR_COUNT);
      chk({4'h0, d}, 8'h00);
      $display("free run and stop done");
      summarize();
   end
endmodule : cssio_top_tb
